// ===== verilog/tcc_tx_capture.sv
// Purpose: two-channel transmit character capture with error status
// Assumes: clock is the transmit character clock derived from the reference;
//          configuration latch bits arrive on the clock's own domain
// Notes: clk_en freezes the core-clock state only; link logic follows its own clock
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE1] each 10-bit character is taken on the rising edge of the chosen interface clock.
// [RULE2] each channel picks its interface clock from its own clock select latch.
// [RULE3] the error output rises when the channel's phase-align buffer underflows or overflows.
// [RULE4] a buffer fault holds the error output high until the buffer is re-centered.
// [RULE5] with the self-test enable latch at 0 the error output shows self-test progress.
// [RULE6] during self-test the error output pulses for one character clock every 511 characters.
// [RULE7] the error output stays high while both serial output enables of the channel are 0.
// [RULE8] the error output stays high while the channel's reference clock is absent.
// [RULE9] the error output changes on the reference-derived clock.
// [RULE10] select 0 takes characters on the host input clock, otherwise on the reference clock.
// [RULE11] writing the recenter latch as 0 re-centers the phase-align buffer.
// [RULE12] the host keeps its input clock frequency-coherent and within half a cycle of drift.
// [RULE13] in half-rate mode characters are taken on both edges of the reference clock.
// [RULE14] two independent channels each own inputs, selection, buffer, latches and error.
module tcc_tx_capture
    import tcc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [CHANNELS-1:0] tx_input_clock,
    input wire logic [CHANNELS-1:0][CHAR_W-1:0] tx_char_in,
    input wire logic [CHANNELS-1:0] reference_clock_in,
    input wire logic [CHANNELS-1:0] tx_clock_select,
    input wire logic [CHANNELS-1:0] phase_buffer_recenter,
    input wire logic [CHANNELS-1:0] tx_selftest_enable,
    input wire logic [CHANNELS-1:0] serial_out1_enable,
    input wire logic [CHANNELS-1:0] serial_out2_enable,
    input wire logic [CHANNELS-1:0] half_rate,
    input wire logic [CHANNELS-1:0] ser_ready,
    output logic [CHANNELS-1:0] tx_path_error,
    output logic [CHANNELS-1:0][CHAR_W-1:0] tx_char_out,
    output logic [CHANNELS-1:0] tx_char_valid,
    output logic [CHANNELS-1:0][CHAR_W-1:0] tx_char_late,
    output logic [CHANNELS-1:0] tx_late_valid,
    output logic [CHANNELS-1:0] tx_fill_ready
);
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan // [RULE14]
        tcc_fifo_if #(.W(CHAR_W), .AW(FIFO_AW)) pab ();

        // ---- core clock domain: configuration decode
        wire use_input_clk = tx_clock_select[ch] == SEL_INPUT_CLOCK; // [RULE2] [RULE10]
        wire recentering = phase_buffer_recenter[ch] == RECENTER_ACTIVE; // [RULE11]
        wire builtin_self_test_on = tx_selftest_enable[ch] == BUILTIN_SELF_TEST_ACTIVE; // [RULE5]
        wire pll_down = (serial_out1_enable[ch] == SER_OUT_OFF)
                      & (serial_out2_enable[ch] == SER_OUT_OFF); // [RULE7]

        // link side held in reset while re-centering or while not selected
        logic link_rst_reg;
        logic rd_rst_reg;
        always_ff @(posedge clock) begin
            if (srst) begin
                link_rst_reg <= 1'b1;
                rd_rst_reg <= 1'b1;
            end else if (clk_en) begin
                link_rst_reg <= recentering | ~use_input_clk; // [RULE11]
                rd_rst_reg <= recentering | ~use_input_clk;
            end
        end

        // ---- link domain: capture on the host input clock
        logic lrst_s1_reg, lrst_s2_reg;
        logic [CHAR_W-1:0] cap_reg;
        logic cap_valid_reg;
        logic ovf_tgl_reg;
        logic fill_ready_reg;
        always_ff @(posedge tx_input_clock[ch]) begin
            lrst_s1_reg <= link_rst_reg;
            lrst_s2_reg <= lrst_s1_reg;
        end
        always_ff @(posedge tx_input_clock[ch]) begin
            if (lrst_s2_reg) begin
                cap_reg <= CHAR_RESET;
                cap_valid_reg <= 1'b0;
                ovf_tgl_reg <= 1'b0;
                fill_ready_reg <= 1'b0;
            end else begin
                cap_reg <= tx_char_in[ch]; // [RULE1]
                cap_valid_reg <= 1'b1;
                ovf_tgl_reg <= ovf_tgl_reg ^ (cap_valid_reg & ~pab.wr_ready); // [RULE3]
                fill_ready_reg <= pab.wr_ready;
            end
        end
        assign pab.wr_valid = cap_valid_reg;
        assign pab.wr_data = cap_reg;
        assign tx_fill_ready[ch] = fill_ready_reg;

        tcc_phase_fifo #(.W(CHAR_W), .D(FIFO_DEPTH)) u_pab (
            .wclk(tx_input_clock[ch]),
            .wrst(lrst_s2_reg),
            .rclk(clock),
            .rrst(rd_rst_reg | srst),
            .rce(clk_en),
            .wr(pab.wr_side),
            .rd(pab.rd_side)
        );

        // ---- core domain: overflow event crossing
        logic ovf_s1_reg, ovf_s2_reg, ovf_s3_reg;
        always_ff @(posedge clock) begin
            if (srst) begin
                ovf_s1_reg <= 1'b0;
                ovf_s2_reg <= 1'b0;
                ovf_s3_reg <= 1'b0;
            end else if (clk_en) begin
                ovf_s1_reg <= ovf_tgl_reg;
                ovf_s2_reg <= ovf_s1_reg;
                ovf_s3_reg <= ovf_s2_reg;
            end
        end
        wire ovf_evt = (ovf_s2_reg ^ ovf_s3_reg) & ~link_rst_reg;

        // ---- read state machine: fill to the centre, then drain
        tcc_rd_e rd_state_reg, rd_state_next;
        always_comb begin
            rd_state_next = rd_state_reg;
            unique case (rd_state_reg)
                RD_IDLE: begin
                    if (!rd_rst_reg) begin
                        rd_state_next = RD_FILL;
                    end
                end
                RD_FILL: begin
                    if (pab.rd_level >= CENTER_FILL) begin
                        rd_state_next = RD_RUN;
                    end
                end
                RD_RUN: begin
                    rd_state_next = RD_RUN;
                end
            endcase
            if (rd_rst_reg) begin
                rd_state_next = RD_IDLE; // [RULE11]
            end
        end
        always_ff @(posedge clock) begin
            if (srst) begin
                rd_state_reg <= RD_IDLE;
            end else if (clk_en) begin
                rd_state_reg <= rd_state_next;
            end
        end
        assign pab.rd_ready = (rd_state_reg == RD_RUN) & ser_ready[ch];
        wire unf_evt = pab.rd_ready & ~pab.rd_valid; // [RULE3]

        // ---- sticky buffer fault, event beats the clear
        logic fault_reg;
        always_ff @(posedge clock) begin
            if (srst) begin
                fault_reg <= 1'b0;
            end else if (clk_en) begin
                fault_reg <= (ovf_evt | unf_evt) | (fault_reg & ~recentering); // [RULE4]
            end
        end

        // ---- reference clock presence watch
        logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
        logic [4:0] ref_idle_reg;
        logic ref_missing_reg;
        wire ref_edge = ref_s2_reg ^ ref_s3_reg;
        always_ff @(posedge clock) begin
            if (srst) begin
                ref_s1_reg <= 1'b0;
                ref_s2_reg <= 1'b0;
                ref_s3_reg <= 1'b0;
                ref_idle_reg <= '0;
                ref_missing_reg <= 1'b1;
            end else if (clk_en) begin
                ref_s1_reg <= reference_clock_in[ch];
                ref_s2_reg <= ref_s1_reg;
                ref_s3_reg <= ref_s2_reg;
                if (ref_edge) begin
                    ref_idle_reg <= '0;
                end else if (ref_idle_reg != REF_LOSS_CYCLES) begin
                    ref_idle_reg <= ref_idle_reg + 5'h01;
                end
                ref_missing_reg <= ~ref_edge & (ref_idle_reg == REF_LOSS_CYCLES); // [RULE8]
            end
        end

        // ---- self-test pass counter
        logic [8:0] builtin_self_test_cnt_reg;
        logic builtin_self_test_pulse_reg;
        wire builtin_self_test_wrap = builtin_self_test_cnt_reg == BUILTIN_SELF_TEST_LAST;
        always_ff @(posedge clock) begin
            if (srst) begin
                builtin_self_test_cnt_reg <= '0;
                builtin_self_test_pulse_reg <= 1'b0;
            end else if (clk_en) begin
                builtin_self_test_cnt_reg <= (!builtin_self_test_on || builtin_self_test_wrap) ? 9'h000 : builtin_self_test_cnt_reg + 9'h001; // [RULE6]
                builtin_self_test_pulse_reg <= builtin_self_test_on & builtin_self_test_wrap; // [RULE6]
            end
        end

        // ---- error output, registered on the character clock
        logic err_reg;
        wire err_next = pll_down | ref_missing_reg // [RULE7] [RULE8]
                      | (builtin_self_test_on ? builtin_self_test_pulse_reg : fault_reg); // [RULE5] [RULE3]
        always_ff @(posedge clock) begin
            if (srst) begin
                err_reg <= 1'b1;
            end else if (clk_en) begin
                err_reg <= err_next; // [RULE9]
            end
        end
        assign tx_path_error[ch] = err_reg;

        // ---- character output: buffer path or reference-clock capture
        logic [CHAR_W-1:0] fall_cap_reg;
        always_ff @(negedge clock) begin
            if (clk_en && half_rate[ch]) begin
                fall_cap_reg <= tx_char_in[ch]; // [RULE13]
            end
        end

        logic [CHAR_W-1:0] out_reg, late_reg;
        logic out_valid_reg, late_valid_reg;
        wire buf_take = pab.rd_ready & pab.rd_valid;
        always_ff @(posedge clock) begin
            if (srst) begin
                out_reg <= CHAR_RESET;
                late_reg <= CHAR_RESET;
                out_valid_reg <= 1'b0;
                late_valid_reg <= 1'b0;
            end else if (clk_en) begin
                if (use_input_clk) begin
                    out_reg <= pab.rd_data;
                    out_valid_reg <= buf_take; // [RULE10]
                    late_valid_reg <= 1'b0;
                end else begin
                    out_reg <= tx_char_in[ch]; // [RULE1] [RULE10]
                    out_valid_reg <= 1'b1;
                    late_reg <= fall_cap_reg;
                    late_valid_reg <= half_rate[ch]; // [RULE13]
                end
            end
        end
        assign tx_char_out[ch] = out_reg;
        assign tx_char_valid[ch] = out_valid_reg;
        assign tx_char_late[ch] = late_reg;
        assign tx_late_valid[ch] = late_valid_reg;
    end
endmodule
`default_nettype wire

// ===== verilog/tcc_pkg.sv
// Purpose: shared constants for the transmit character capture block
// Assumes: two channels, 10-bit characters, 8-word phase-align buffer
// Notes: latch polarities follow the configuration latch encoding
package tcc_pkg;
    localparam int CHAR_W = 10;
    localparam int CHANNELS = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_AW = 3;
    localparam logic [FIFO_AW:0] CENTER_FILL = 4'h4;
    localparam logic [8:0] BUILTIN_SELF_TEST_PERIOD = 9'h1ff;
    localparam logic [8:0] BUILTIN_SELF_TEST_LAST = 9'h1fe;
    localparam logic [4:0] REF_LOSS_CYCLES = 5'h10;
    localparam logic SEL_INPUT_CLOCK = 1'h0;
    localparam logic RECENTER_ACTIVE = 1'h0;
    localparam logic BUILTIN_SELF_TEST_ACTIVE = 1'h0;
    localparam logic SER_OUT_OFF = 1'h0;
    localparam logic [CHAR_W-1:0] CHAR_RESET = 10'h000;

    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_FILL = 3'b010,
        RD_RUN = 3'b100
    } tcc_rd_e;
endpackage

// ===== verilog/tcc_fifo_if.sv
// Purpose: carrier between the capture logic and the phase-align buffer
// Assumes: write side on the link clock, read side on the core clock
// Notes: level is seen from the read side
`timescale 1ns/1ps
`default_nettype none
interface tcc_fifo_if #(parameter int W = 10, parameter int AW = 3);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic [AW:0] rd_level;
    modport wr_side(input wr_valid, input wr_data, output wr_ready);
    modport rd_side(output rd_valid, output rd_data, output rd_level, input rd_ready);
    modport wr_user(output wr_valid, output wr_data, input wr_ready);
    modport rd_user(input rd_valid, input rd_data, input rd_level, output rd_ready);
endinterface
`default_nettype wire

// ===== verilog/tcc_phase_fifo.sv
// Purpose: dual-clock phase-align buffer with gray-coded pointers
// Assumes: depth is a power of two; resets are synchronous to each side
// Notes: read side frozen while rce is low
`timescale 1ns/1ps
`default_nettype none
module tcc_phase_fifo #(
    parameter int W = 10,
    parameter int D = 8
) (
    input wire logic wclk,
    input wire logic wrst,
    input wire logic rclk,
    input wire logic rrst,
    input wire logic rce,
    tcc_fifo_if.wr_side wr,
    tcc_fifo_if.rd_side rd
);
    localparam int AW = $clog2(D);

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction

    logic [W-1:0] mem_reg [D];
    logic [AW:0] wbin_reg, wgray_reg, rbin_reg, rgray_reg;
    logic [AW:0] rg_s1_reg, rg_s2_reg, wg_s1_reg, wg_s2_reg;
    logic wfree_reg, rempty_reg;
    logic [AW:0] wbin_next, rbin_next, wgray_next, rgray_next, wsync_bin;
    wire push = wr.wr_valid & wfree_reg;
    wire pop = rd.rd_ready & ~rempty_reg & rce;

    assign wbin_next = wbin_reg + {{AW{1'b0}}, push};
    assign rbin_next = rbin_reg + {{AW{1'b0}}, pop};
    assign wgray_next = bin2gray(wbin_next);
    assign rgray_next = bin2gray(rbin_next);
    assign wr.wr_ready = wfree_reg;
    assign rd.rd_valid = ~rempty_reg;
    assign rd.rd_data = mem_reg[rbin_reg[AW-1:0]];
    assign rd.rd_level = wsync_bin - rbin_reg;

    always_comb begin
        wsync_bin[AW] = wg_s2_reg[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            wsync_bin[i] = wsync_bin[i+1] ^ wg_s2_reg[i];
        end
    end

    always_ff @(posedge wclk) begin
        if (push) begin
            mem_reg[wbin_reg[AW-1:0]] <= wr.wr_data;
        end
    end

    always_ff @(posedge wclk) begin
        if (wrst) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
            rg_s1_reg <= '0;
            rg_s2_reg <= '0;
            wfree_reg <= 1'b0;
        end else begin
            wbin_reg <= wbin_next;
            wgray_reg <= wgray_next;
            rg_s1_reg <= rgray_reg;
            rg_s2_reg <= rg_s1_reg;
            wfree_reg <= wgray_next != {~rg_s2_reg[AW:AW-1], rg_s2_reg[AW-2:0]};
        end
    end

    always_ff @(posedge rclk) begin
        if (rrst) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            wg_s1_reg <= '0;
            wg_s2_reg <= '0;
            rempty_reg <= 1'b1;
        end else if (rce) begin
            rbin_reg <= rbin_next;
            rgray_reg <= rgray_next;
            wg_s1_reg <= wgray_reg;
            wg_s2_reg <= wg_s1_reg;
            rempty_reg <= rgray_next == wg_s2_reg;
        end
    end
endmodule
`default_nettype wire

// ===== verif/tcc_tx_capture_sva.sv
// Purpose: port-level checks of the transmit capture block
// Assumes: detailed checks on channel 0, reference presence seen as a toggling pin
// Notes: an idle counter stands in for the reference-loss detector
`timescale 1ns/1ps
`default_nettype none
module tcc_tx_capture_sva
    import tcc_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic [CHANNELS-1:0] reference_clock_in,
    input wire logic [CHANNELS-1:0] tx_clock_select,
    input wire logic [CHANNELS-1:0] phase_buffer_recenter,
    input wire logic [CHANNELS-1:0] tx_selftest_enable,
    input wire logic [CHANNELS-1:0] serial_out1_enable,
    input wire logic [CHANNELS-1:0] serial_out2_enable,
    input wire logic [CHANNELS-1:0] half_rate,
    input wire logic [CHANNELS-1:0][CHAR_W-1:0] tx_char_in,
    input wire logic [CHANNELS-1:0] tx_path_error,
    input wire logic [CHANNELS-1:0][CHAR_W-1:0] tx_char_out,
    input wire logic [CHANNELS-1:0] tx_char_valid,
    input wire logic [CHANNELS-1:0][CHAR_W-1:0] tx_char_late,
    input wire logic [CHANNELS-1:0] tx_late_valid
);
    logic ref_q;
    logic [4:0] idle_cnt;
    logic [CHAR_W-1:0] fall_q;
    wire logic pll_up = serial_out1_enable[0] | serial_out2_enable[0];
    wire logic ref_ok = idle_cnt < 5'h04;
    always_ff @(posedge clock) begin
        ref_q <= reference_clock_in[0];
        if (srst) begin
            idle_cnt <= 5'h1f;
        end else if (ref_q != reference_clock_in[0]) begin
            idle_cnt <= 5'h00;
        end else if (idle_cnt != 5'h1f) begin
            idle_cnt <= idle_cnt + 5'h01;
        end
    end
    // character present at the falling edge, for the half-rate pair
    always_ff @(negedge clock) begin
        fall_q <= tx_char_in[0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_pll_down_err: assert property (clk_en && !pll_up |=> tx_path_error[0])
        else $error("error low while synthesizer down");
    a_pll_down_b: assert property (clk_en && !(serial_out1_enable[1] | serial_out2_enable[1])
        |=> tx_path_error[1]) else $error("error b low while synthesizer down");
    a_ref_capture: assert property ((clk_en && tx_clock_select[0])[*2]
        |-> tx_char_valid[0] && tx_char_out[0] == $past(tx_char_in[0]))
        else $error("reference capture mismatch");
    a_ref_capture_b: assert property ((clk_en && tx_clock_select[1])[*2]
        |-> tx_char_valid[1] && tx_char_out[1] == $past(tx_char_in[1]))
        else $error("reference capture b mismatch");
    a_half_late: assert property ((clk_en && tx_clock_select[0] && half_rate[0])[*3]
        |-> tx_late_valid[0] && tx_char_late[0] == $past(fall_q))
        else $error("falling edge character mismatch");
    a_ref_loss_err: assert property (idle_cnt >= 5'h18 |-> tx_path_error[0])
        else $error("error low without reference");
    a_recenter_clear: assert property ((!phase_buffer_recenter[0] && tx_selftest_enable[0]
        && pll_up && ref_ok)[*8] |-> !tx_path_error[0]) else $error("error held in recenter");
    a_selftest_pulse: assert property ($rose(tx_path_error[0]) && !tx_selftest_enable[0]
        && !$past(tx_selftest_enable[0]) && pll_up && $past(pll_up) && ref_ok
        |=> !tx_path_error[0]) else $error("self-test pulse too wide");
endmodule
`default_nettype wire

// ===== verif/tcc_host_model.sv
// Purpose: host model driving the link clock and characters
// Assumes: 12 ns link clock that runs only while run is high
// Notes: idle lines show the inverse of the last character
`timescale 1ns/1ps
`default_nettype none
module tcc_host_model
    import tcc_pkg::*;
(
    input wire logic run,
    output logic link_clk,
    output logic [CHAR_W-1:0] char_out
);
    initial begin
        link_clk = 1'b0;
        char_out = CHAR_RESET;
    end
    always begin
        #6;
        link_clk = run ? ~link_clk : 1'b0;
    end
    // counting characters make order and gaps visible
    always @(posedge link_clk) begin
        char_out <= #1 char_out + 10'h001;
    end
    always @(negedge run) begin
        char_out = ~char_out;
    end
endmodule
`default_nettype wire

// ===== verif/tx_char_capture_and_error_status_tb.sv
// Purpose: self-checking bench of the transmit capture block
// Assumes: host models on the link side, reference pin toggled by the bench
// Notes: channel 0 runs underflow, channel 1 overflow
`timescale 1ns/1ps
`default_nettype none
module tx_char_capture_and_error_status_tb
    import tcc_pkg::*;
;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic clk_en = 1'b1;
    logic [CHANNELS-1:0] sel, recenter, stest, oe1, oe2, half, ser_rdy, ref_on, run;
    logic [CHANNELS-1:0] ref_clk, link_clk, err, valid, late_valid, fill_rdy;
    logic [CHANNELS-1:0][CHAR_W-1:0] ref_char, host_char, chars, out, late;
    logic [CHAR_W-1:0] prev;
    int n_errors = 0;
    int check_count = 0;
    int n;
    integer seed = 97499;
    always #10 clock = ~clock;
    always @(posedge clock) ref_clk <= ref_clk ^ ref_on;
    for (genvar g = 0; g < CHANNELS; g++) begin : g_host
        tcc_host_model host_u (.run(run[g]), .link_clk(link_clk[g]), .char_out(host_char[g]));
        assign chars[g] = sel[g] ? ref_char[g] : host_char[g];
    end
    tcc_tx_capture dut_u (.clock(clock), .srst(srst), .clk_en(clk_en),
        .tx_input_clock(link_clk), .tx_char_in(chars), .reference_clock_in(ref_clk),
        .tx_clock_select(sel), .phase_buffer_recenter(recenter), .tx_selftest_enable(stest),
        .serial_out1_enable(oe1), .serial_out2_enable(oe2), .half_rate(half),
        .ser_ready(ser_rdy), .tx_path_error(err), .tx_char_out(out), .tx_char_valid(valid),
        .tx_char_late(late), .tx_late_valid(late_valid), .tx_fill_ready(fill_rdy));
    function automatic logic exp_err(input logic o1, input logic o2);
        return !(o1 || o2);
    endfunction
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h got %h", name, exp, got);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge clock);
        #2;
    endtask
    task automatic wait_err(input int lim);
        n = 0;
        while (err[0] !== 1'b1 && n < lim) begin
            cyc(1);
            n++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        conclude();
    end
    initial begin
        {sel, recenter, stest, oe1, oe2, ref_on} = '1;
        {half, ser_rdy, run, ref_clk, ref_char} = '0;
        cyc(20);
        srst = 1'b0;
        cyc(10);
        check("err idle", err, 2'b00);
        repeat (40) begin
            ref_char[0] = CHAR_W'($random(seed));
            ref_char[1] = CHAR_W'($random(seed));
            cyc(1);
            check("out a", out[0], ref_char[0]);
            check("out b", out[1], ref_char[1]);
            check("valid", valid, 2'b11);
        end
        half[0] = 1'b1;
        repeat (20) begin
            ref_char[0] = CHAR_W'($random(seed));
            prev = ref_char[0];
            @(negedge clock);
            #2;
            ref_char[0] = CHAR_W'($random(seed));
            cyc(1);
            check("late", late[0], prev);
            check("out half", out[0], ref_char[0]);
        end
        half[0] = 1'b0;
        for (int i = 0; i < 4; i++) begin
            {oe1[0], oe2[0]} = i[1:0];
            cyc(3);
            check("pll", err[0], exp_err(oe1[0], oe2[0]));
            check("pll b", err[1], 1'b0);
        end
        ref_on[0] = 1'b0;
        cyc(30);
        check("ref lost", err, 2'b01);
        ref_on[0] = 1'b1;
        cyc(10);
        check("ref back", err[0], 1'b0);
        stest[0] = 1'b0;
        wait_err(600);
        cyc(1);
        check("pulse width", err[0], 1'b0);
        wait_err(600);
        check("pulse period", n + 1, 511);
        stest[0] = 1'b1;
        {sel[0], ser_rdy[0], recenter[0], run[0]} = 4'h5;
        cyc(6);
        recenter[0] = 1'b1;
        n = 0;
        for (int i = 0; i < 46; i++) begin
            if (i == 6) run[0] = 1'b0;
            cyc(1);
            if (valid[0] === 1'b1) begin
                if (n > 0) check("order", out[0], prev + 10'h001);
                prev = out[0];
                n++;
            end
        end
        check("drained", n >= 4, 1'b1);
        check("underflow", err[0], 1'b1);
        cyc(30);
        check("sticky", err[0], 1'b1);
        {recenter[0], run[0]} = 2'h1;
        cyc(10);
        check("recenter", err[0], 1'b0);
        {sel[1], recenter[1], run[1]} = 3'h1;
        cyc(6);
        recenter[1] = 1'b1;
        cyc(20);
        check("overflow", err, 2'b10);
        check("full", fill_rdy[1], 1'b0);
        recenter[1] = 1'b0;
        cyc(10);
        check("recenter b", err[1], 1'b0);
        conclude();
    end
endmodule
bind tcc_tx_capture tcc_tx_capture_sva sva_u (.clock(clock), .srst(srst), .clk_en(clk_en),
    .reference_clock_in(reference_clock_in), .tx_clock_select(tx_clock_select),
    .phase_buffer_recenter(phase_buffer_recenter), .tx_selftest_enable(tx_selftest_enable),
    .serial_out1_enable(serial_out1_enable), .serial_out2_enable(serial_out2_enable),
    .half_rate(half_rate), .tx_char_in(tx_char_in), .tx_path_error(tx_path_error),
    .tx_char_out(tx_char_out), .tx_char_valid(tx_char_valid), .tx_char_late(tx_char_late),
    .tx_late_valid(tx_late_valid));
`default_nettype wire
